// [dv/fetx_link_partner.sv]
// Far-end transmitter: MLT-3 codes an NRZI one-per-change bit stream.
// Assumes the bench changes the bit just after a falling edge.
`timescale 1ns/1ns
module fetx_link_partner
    import fetx_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_bit,
    output logic [1:0]      o_level
);
    logic [1:0] ph_q = PH_RESET;
    wire  [1:0] ph_d = ph_q + {1'b0, i_bit};
    // Odd phases are the outer levels, so the phase code doubles as the level.
    // The level comes from the register so that it only moves at a rising edge.
    assign o_level = ph_q[0] ? ph_q : LVL_ZERO;
    always_ff @(posedge i_ref_clk) ph_q <= ph_d;
endmodule

// [dv/fetx_properties.sv]
// Port-level properties of the line coder.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ns
module fetx_properties
    import fetx_pkg::*;
(
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic [1:0] i_rx_level,
    input wire logic       o_tx_ready,
    input wire logic       o_tx_nrzi,
    input wire logic       o_tx_drive_pos,
    input wire logic       o_tx_drive_neg,
    input wire logic       o_rx_nrz,
    input wire logic       o_rx_symbol_valid,
    input wire logic       o_signal_detect
);
    // ==================
    // Helpers.
    logic [2:0] cnt_q;
    logic [6:0] quiet_q;
    logic [1:0] lvl_q;
    logic       last_pos_q;
    wire logic  lvl_same;
    assign lvl_same = (i_rx_level == lvl_q);
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q      <= 3'h0;
            quiet_q    <= 7'h00;
            lvl_q      <= LVL_ZERO;
            last_pos_q <= 1'b0;
        end else begin
            cnt_q      <= cnt_q + 3'(cnt_q != 3'h7);
            quiet_q    <= lvl_same ? quiet_q + 7'(quiet_q != 7'h7F) : 7'h00;
            lvl_q      <= i_rx_level;
            last_pos_q <= o_tx_drive_pos | (last_pos_q & ~o_tx_drive_neg);
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ==================
    // Properties.
    property p_excl; !(o_tx_drive_pos && o_tx_drive_neg); endproperty
    a_excl: assert property (p_excl) else $error("both drive phases high");
    property p_hold; $stable(o_tx_nrzi) |-> $stable({o_tx_drive_pos, o_tx_drive_neg}); endproperty
    a_hold: assert property (p_hold) else $error("drive moved on a zero");
    property p_pos; $rose(o_tx_drive_pos) |-> !last_pos_q && $changed(o_tx_nrzi); endproperty
    a_pos: assert property (p_pos) else $error("positive level out of turn");
    property p_neg; $rose(o_tx_drive_neg) |-> last_pos_q; endproperty
    a_neg: assert property (p_neg) else $error("negative level out of turn");
    property p_ready; cnt_q == 3'h2 |-> o_tx_ready && !$past(o_tx_ready); endproperty
    a_ready: assert property (p_ready) else $error("ready not at second edge");
    property p_sym; o_rx_symbol_valid |=> !o_rx_symbol_valid [*4] ##1 o_rx_symbol_valid; endproperty
    a_sym: assert property (p_sym) else $error("symbol spacing wrong");
    // A level change sampled at one edge shows on the output two edges later.
    property p_nrz;
        cnt_q == 3'h7 |-> o_rx_nrz == ($past(i_rx_level, 2) != $past(i_rx_level, 3));
    endproperty
    a_nrz: assert property (p_nrz) else $error("receive bit wrong");
    property p_quiet; quiet_q > 7'h44 |-> !o_signal_detect; endproperty
    a_quiet: assert property (p_quiet) else $error("detect held on a quiet line");
    c_sd: cover property ($rose(o_signal_detect));
    c_sym: cover property (o_rx_symbol_valid);
    c_neg: cover property ($rose(o_tx_drive_neg));
endmodule
bind fetx_line_coder fetx_properties chk_u (.i_ref_clk, .i_rst, .i_rx_level, .o_tx_ready,
    .o_tx_nrzi, .o_tx_drive_pos, .o_tx_drive_neg, .o_rx_nrz, .o_rx_symbol_valid, .o_signal_detect);

// [dv/tb.sv]
// Self-checking bench of the line coder with a link partner on receive.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/1ns
module tb;
    import fetx_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic       tx_bit = 1'b0;
    logic       p_bit = 1'b0;
    logic [1:0] lvl;
    logic       rdy, nrzi, pos, neg, nrz, sv, sd;
    logic [4:0] sym;
    int         err_total = 0;
    int         samples_checked = 0;
    fetx_line_coder dut_u (.i_ref_clk(clk), .i_rst(rst), .i_port_address_pins(addr),
        .i_tx_bit(tx_bit), .o_tx_ready(rdy), .o_tx_nrzi(nrzi), .o_tx_drive_pos(pos),
        .o_tx_drive_neg(neg), .i_rx_level(lvl), .o_rx_nrz(nrz), .o_rx_symbol(sym),
        .o_rx_symbol_valid(sv), .o_signal_detect(sd));
    fetx_link_partner lp_u (.i_ref_clk(clk), .i_bit(p_bit), .o_level(lvl));
    initial begin
        forever #10 clk = ~clk;
    end
    // ==================
    // Shared tasks.
    task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==================
    // Scenarios.
    task automatic t_tx(input logic [4:0] a);
        logic [10:0] scr;
        logic [1:0]  ph;
        logic        nz, s, b;
        int          i;
        rst = 1'b1;
        addr = a;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        scr = {SCR_SEED_FIX, a[SEED_ADDR_HI:SEED_ADDR_LO]};
        nz = 1'b0;
        ph = PH_RESET;
        i = 0;
        while (rdy !== 1'b1 && i < 8) begin
            @(negedge clk);
            i++;
        end
        chk("tx_ready", 5'h1, 5'(rdy));
        // The long run of ones shows the key stream runs on regardless of data.
        for (i = 0; i < 200; i++) begin
            b = (i < 100) ? i[0] ^ i[2] : 1'b1;
            tx_bit = b;
            @(negedge clk);
            s = b ^ scr[10] ^ scr[8];
            scr = {scr[9:0], scr[10] ^ scr[8]};
            nz = nz ^ s;
            ph = ph + {1'b0, s};
            chk("tx_nrzi", 5'(nz), 5'(nrzi));
            chk("tx_pos", 5'(ph == PH_POS), 5'(pos));
            chk("tx_neg", 5'(ph == PH_NEG), 5'(neg));
        end
        tx_bit = 1'b0;
        $display("test tx %h done", a);
    endtask
    task automatic t_rx;
        logic [2:0] h;
        logic [4:0] nh;
        logic       b;
        int         i;
        int         gap;
        int         nsv;
        h = 3'h0;
        nh = 5'h00;
        gap = 0;
        nsv = 0;
        for (i = 0; i < 1310; i++) begin
            @(negedge clk);
            nh = {nh[3:0], nrz};
            gap++;
            chk("rx_nrz", 5'(h[2]), 5'(nrz));
            if (sv === 1'b1) begin
                chk("rx_sym", nh, sym);
                if (nsv > 0) chk("rx_sym_gap", 5'h5, 5'(gap));
                gap = 0;
                nsv++;
            end
            if (i == 600) chk("sd_pulses", 5'h0, 5'(sd));
            if (i == 1229) chk("sd_data", 5'h1, 5'(sd));
            if (i == 1309) chk("sd_quiet", 5'h0, 5'(sd));
            b = (i < 600) ? (i % 100 < 2) : (i < 1230) ? (i[0] ^ i[1] ^ i[4]) : 1'b0;
            p_bit = b;
            h = {h[1:0], b};
        end
        // One symbol in every five bit times over the whole run.
        chk("rx_sym_count", 5'h1, 5'(nsv == 262));
        $display("test rx done");
    endtask
    initial begin
        t_tx(5'h1E);
        t_tx(5'h03);
        t_rx();
        conclude();
    end
    // The tests need about 1800 cycles; the limit allows 5000.
    initial begin
        #100000;
        err_total++;
        conclude();
    end
endmodule

// [inc/fetx_pkg.sv]
// Constants shared by the 100 Mb/s twisted-pair line coder.
// Assumes one bit time per cycle of the reference clock and a synchronous
// upstream encoder and equaliser on that same clock.
//
// Notes on behaviour
// - Scrambler: free-running closed-loop 11-bit LFSR.
// - Scrambled bit is NRZ bit XOR key.
// - Seed taken from port address bits 4:1.
// - NRZI encode: one toggles, zero holds.
// - NRZI split into two alternating drive streams.
// - Only MLT-3 output; no binary option.
// - Receive path feeds the nibble path downstream.
// - MLT-3 level change decodes as one.
// - NRZ is one when NRZI bit changes.
// - Five received bits form one symbol.
// - Link pulses never raise signal detect.
package fetx_pkg;

    // ========================================================================
    // Clock and timing.
    localparam int unsigned CLK_HZ = 50_000_000;

    // ========================================================================
    // Scrambler.
    localparam int unsigned    SCR_W        = 11;
    localparam int unsigned    SCR_TAP_HI   = 10;
    localparam int unsigned    SCR_TAP_LO   = 8;
    localparam logic [10:0]    SCR_RESET    = 11'h7FF;
    localparam logic [6:0]     SCR_SEED_FIX = 7'h5A;
    localparam int unsigned    ADDR_W       = 5;
    localparam int unsigned    SEED_ADDR_HI = 4;
    localparam int unsigned    SEED_ADDR_LO = 1;

    // ========================================================================
    // MLT-3 line levels as seen on the receive input.
    localparam logic [1:0] LVL_ZERO = 2'h0;
    localparam logic [1:0] LVL_POS  = 2'h1;
    localparam logic [1:0] LVL_NEG  = 2'h3;

    // MLT-3 phase: 0 zero, 1 positive, 2 zero, 3 negative.
    localparam logic [1:0] PH_RESET = 2'h0;
    localparam logic [1:0] PH_POS   = 2'h1;
    localparam logic [1:0] PH_NEG   = 2'h3;

    // ========================================================================
    // Receive symbol and signal detect.
    localparam int unsigned SYM_W        = 5;
    localparam logic [2:0]  SYM_LAST     = 3'h4;
    localparam logic [5:0]  SD_GAP_MAX   = 6'h3F;
    localparam logic [8:0]  SD_RUN_MIN   = 9'h1FF;

    typedef enum logic [1:0] {
        FETX_ST_SYNC,
        FETX_ST_LOAD,
        FETX_ST_RUN
    } fetx_state_e;

endpackage

// [logic/fetx_line_coder.sv]
// Line coder of a 100 Mb/s twisted-pair port: scrambler, NRZI and MLT-3 on
// transmit; MLT-3 and NRZI decoding, signal detect and 5-bit symbols on receive.
// Assumes the encoder and the equaliser sit on i_ref_clk; address pins do not.
`timescale 1ns/1ns

module fetx_line_coder
    import fetx_pkg::*;
(
    // Clock and reset.
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst,
    // Port address straps.
    input  wire logic [ADDR_W-1:0]  i_port_address_pins,
    // Transmit NRZ bits from the code-group encoder.
    input  wire logic               i_tx_bit,
    // Transmit line drive.
    output logic                    o_tx_ready,
    output logic                    o_tx_nrzi,
    output logic                    o_tx_drive_pos,
    output logic                    o_tx_drive_neg,
    // Receive levels from the equaliser.
    input  wire logic [1:0]         i_rx_level,
    // Receive results.
    output logic                    o_rx_nrz,
    output logic [SYM_W-1:0]        o_rx_symbol,
    output logic                    o_rx_symbol_valid,
    output logic                    o_signal_detect
);

    // ========================================================================
    // Address pin synchroniser and seed load sequence.
    logic [ADDR_W-1:0] addr_meta_q;
    logic [ADDR_W-1:0] addr_sync_q;
    fetx_state_e       state_q;
    fetx_state_e       state_d;

    // The synchroniser has no reset on purpose. The seed is taken two edges
    // after release, so a reset here would hand the seed load zeros. The
    // limitation is that the straps must be settled by the last edge before release.
    always_ff @(posedge i_ref_clk) begin
        addr_meta_q <= i_port_address_pins;
        addr_sync_q <= addr_meta_q;
    end

    // The straps need two edges to pass the synchroniser before the seed is
    // taken, so the scrambler runs from its constant for those two cycles.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FETX_ST_SYNC: state_d = FETX_ST_LOAD;
            FETX_ST_LOAD: state_d = FETX_ST_RUN;
            FETX_ST_RUN:  state_d = FETX_ST_RUN;
            default:      state_d = FETX_ST_SYNC;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= FETX_ST_SYNC;
        end else begin
            state_q <= state_d;
        end
    end

    // ========================================================================
    // Scrambler.
    logic [SCR_W-1:0] scr_q;
    logic [SCR_W-1:0] scr_d;
    wire logic        scr_key;
    wire logic [SCR_W-1:0] scr_seed;
    wire logic        seed_take;

    assign scr_key   = scr_q[SCR_TAP_HI] ^ scr_q[SCR_TAP_LO];
    // The fixed upper part keeps the seed non-zero whatever the straps read.
    assign scr_seed  = {SCR_SEED_FIX, addr_sync_q[SEED_ADDR_HI:SEED_ADDR_LO]};
    assign seed_take = (state_q == FETX_ST_LOAD);

    always_comb begin
        if (seed_take) begin
            scr_d = scr_seed;
        end else begin
            scr_d = {scr_q[SCR_W-2:0], scr_key};
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            scr_q <= SCR_RESET;
        end else begin
            scr_q <= scr_d;
        end
    end

    // ========================================================================
    // Transmit NRZI and MLT-3. There is deliberately no bypass path: the pair
    // only ever carries the three-level code.
    wire logic       tx_run;
    wire logic       tx_scr_bit;
    logic            tx_nrzi_q;
    logic [1:0]      tx_phase_q;
    wire logic [1:0] tx_phase_d;

    assign tx_run     = (state_q == FETX_ST_RUN);
    assign tx_scr_bit = tx_run & (i_tx_bit ^ scr_key);
    assign tx_phase_d = tx_phase_q + {1'b0, tx_scr_bit};

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_nrzi_q      <= 1'b0;
            tx_phase_q     <= PH_RESET;
            o_tx_ready     <= 1'b0;
            o_tx_nrzi      <= 1'b0;
            o_tx_drive_pos <= 1'b0;
            o_tx_drive_neg <= 1'b0;
        end else begin
            tx_nrzi_q      <= tx_nrzi_q ^ tx_scr_bit;
            tx_phase_q     <= tx_phase_d;
            o_tx_ready     <= (state_d == FETX_ST_RUN);
            o_tx_nrzi      <= tx_nrzi_q ^ tx_scr_bit;
            o_tx_drive_pos <= (tx_phase_d == PH_POS);
            o_tx_drive_neg <= (tx_phase_d == PH_NEG);
        end
    end

    // ========================================================================
    // Receive MLT-3 to NRZI to NRZ.
    logic [1:0]  rx_level_q;
    logic        rx_nrzi_q;
    logic        rx_nrzi_prev_q;
    wire logic   rx_change;
    wire logic   rx_nrzi_d;
    wire logic   rx_nrz_bit;

    assign rx_change  = (i_rx_level != rx_level_q);
    assign rx_nrzi_d  = rx_nrzi_q ^ rx_change;
    assign rx_nrz_bit = rx_nrzi_q ^ rx_nrzi_prev_q;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_level_q     <= LVL_ZERO;
            rx_nrzi_q      <= 1'b0;
            rx_nrzi_prev_q <= 1'b0;
            o_rx_nrz       <= 1'b0;
        end else begin
            rx_level_q     <= i_rx_level;
            rx_nrzi_q      <= rx_nrzi_d;
            rx_nrzi_prev_q <= rx_nrzi_q;
            o_rx_nrz       <= rx_nrz_bit;
        end
    end

    // ========================================================================
    // Serial to parallel. The boundary is arbitrary; the aligner downstream
    // fixes it, and its nibbles go on to the media independent interface.
    logic [SYM_W-1:0]  rx_shift_q;
    logic [2:0]        rx_cnt_q;
    wire logic [SYM_W-1:0] rx_shift_d;
    wire logic         rx_sym_end;

    assign rx_shift_d = {rx_shift_q[SYM_W-2:0], rx_nrz_bit};
    assign rx_sym_end = (rx_cnt_q == SYM_LAST);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_shift_q        <= '0;
            rx_cnt_q          <= '0;
            o_rx_symbol       <= '0;
            o_rx_symbol_valid <= 1'b0;
        end else begin
            rx_shift_q        <= rx_shift_d;
            rx_cnt_q          <= rx_sym_end ? 3'h0 : rx_cnt_q + 3'h1;
            o_rx_symbol_valid <= rx_sym_end;
            if (rx_sym_end) begin
                o_rx_symbol <= rx_shift_d;
            end
        end
    end

    // ========================================================================
    // Signal detect. Link pulses are isolated bursts separated by long quiet
    // gaps, so detect needs a long run of activity with no gap over the limit.
    // Scrambled idle never holds a level that long; a pulse train always does.
    logic [5:0] sd_gap_q;
    logic [8:0] sd_run_q;
    wire logic  sd_gap_over;

    assign sd_gap_over = (sd_gap_q == SD_GAP_MAX);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sd_gap_q        <= '0;
            sd_run_q        <= '0;
            o_signal_detect <= 1'b0;
        end else begin
            if (rx_change) begin
                sd_gap_q <= '0;
            end else if (!sd_gap_over) begin
                sd_gap_q <= sd_gap_q + 6'h1;
            end
            if (sd_gap_over) begin
                sd_run_q <= '0;
            end else if (sd_run_q != SD_RUN_MIN) begin
                sd_run_q <= sd_run_q + 9'h1;
            end
            o_signal_detect <= !sd_gap_over && (sd_run_q == SD_RUN_MIN);
        end
    end

endmodule
